// [hw/pfb_host.sv]
// Host-side bus sequencer for an asynchronous parallel NOR flash
module pfb_host (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Request port
  input wire logic req_valid,
  output logic req_ready,
  input wire pfb_pkg::pfb_req_t req,
  // Answer port
  output logic rsp_valid,
  output logic [pfb_pkg::DATA_W-1:0] rsp_data,
  output logic [pfb_pkg::SECTOR_W-1:0] rsp_sector,
  // Mode controls
  input wire logic byte_mode,
  input wire logic bypass_mode,
  input wire logic accel_req,
  // Flash pins
  output pfb_pkg::pfb_pins_t pins,
  input wire logic [pfb_pkg::DATA_W-1:0] dq_in
);
  import pfb_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD,
    ST_WR_SET,
    ST_WR_LO,
    ST_WR_END,
    ST_BUF_RD,
    ST_BUF_LD,
    ST_RST
  } pfb_state_t;

  pfb_state_t state_ff, nxt_state;
  pfb_pins_t pins_ff, nxt_pins;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic rst_rec_ff, nxt_rst_rec;
  logic page_valid_ff, nxt_page_valid;
  logic [UADDR_W-PAGE_LSB-1:0] page_ff, nxt_page;
  logic [2:0] step_ff, nxt_step;
  logic [2:0] steps_ff, nxt_steps;
  logic flush_ff, nxt_flush;
  logic [WBUF_AW:0] fill_ff, nxt_fill;
  logic [WBUF_AW:0] idx_ff, nxt_idx;
  logic [UADDR_W-1:0] base_ff, nxt_base;
  logic [DATA_W-1:0] wdata_ff, nxt_wdata;
  logic rsp_valid_ff, nxt_rsp_valid;
  logic [DATA_W-1:0] rsp_data_ff, nxt_rsp_data;
  logic [SECTOR_W-1:0] rsp_sector_ff, nxt_rsp_sector;
  logic buf_wr_en;
  logic [DATA_W-1:0] buf_rd_data;

  // Places an address and write data on the pins; in byte mode the top data pin is the byte address
  function automatic pfb_pins_t drive_bus(input pfb_pins_t p, input logic [UADDR_W-1:0] a,
                                          input logic [DATA_W-1:0] d, input logic bmode, input logic wr);
    pfb_pins_t r;
    r = p;
    r.addr = a[UADDR_W-1:1];
    if (bmode) begin
      r.dq_out = {a[0], 7'h00, d[BYTE_W-1:0]};
      r.dq_oe = {1'b1, 7'h00, {BYTE_W{wr}}};
    end else begin
      r.dq_out = d;
      r.dq_oe = {DATA_W{wr}};
    end
    return r;
  endfunction

  // Address and data of one step of the word program sequence
  function automatic logic [UADDR_W+DATA_W-1:0] prog_step(input logic [2:0] step, input logic [2:0] steps,
                                                          input logic [UADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [2:0] s;
    s = step + (PROG_STEPS_FULL - steps);
    unique case (s)
      3'h0: return {cmd_uaddr(CMD_ADDR1), CMD_UNLOCK1};
      3'h1: return {cmd_uaddr(CMD_ADDR2), CMD_UNLOCK2};
      3'h2: return {cmd_uaddr(CMD_ADDR1), CMD_PROGRAM};
      default: return {a, d};
    endcase
  endfunction

  logic page_hit;
  logic shortened;
  logic [UADDR_W-1:0] flush_addr;
  logic [UADDR_W+DATA_W-1:0] step_word;
  logic [UADDR_W+DATA_W-1:0] first_word;

  assign page_hit = page_valid_ff && !pins_ff.ce_n && (page_ff == req.addr[UADDR_W-1:PAGE_LSB]);
  assign shortened = bypass_mode || accel_req;
  assign flush_addr = base_ff + (byte_mode ? UADDR_W'(idx_ff) : UADDR_W'({idx_ff, 1'b0}));
  assign step_word = prog_step(step_ff, steps_ff, base_ff, wdata_ff);
  // Opening strobe of a program: the first command word, or the program command word in the shortened form
  assign first_word = prog_step(3'h0, shortened ? PROG_STEPS_SHORT : PROG_STEPS_FULL, req.addr, req.wdata);
  assign req_ready = (state_ff == ST_IDLE) && !(req.op == OP_BUF_LOAD && fill_ff == WBUF_FULL);
  assign buf_wr_en = req_valid && req_ready && (req.op == OP_BUF_LOAD);

  always_comb begin
    nxt_state = state_ff;
    nxt_pins = pins_ff;
    nxt_cnt = cnt_ff;
    nxt_rst_rec = rst_rec_ff;
    nxt_page_valid = page_valid_ff;
    nxt_page = page_ff;
    nxt_step = step_ff;
    nxt_steps = steps_ff;
    nxt_flush = flush_ff;
    nxt_fill = fill_ff;
    nxt_idx = idx_ff;
    nxt_base = base_ff;
    nxt_wdata = wdata_ff;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_data = rsp_data_ff;
    nxt_rsp_sector = rsp_sector_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (req_valid && req_ready) begin
          nxt_rsp_sector = sector_index(req.addr);
          nxt_base = req.addr;
          nxt_wdata = req.wdata;
          nxt_step = 3'h0;
          nxt_flush = 1'b0;
          unique case (req.op)
            OP_READ: begin
              // Identifier reads go through here too, with array read timing
              nxt_pins = drive_bus(pins_ff, req.addr, '0, byte_mode, 1'b0);
              nxt_pins.ce_n = 1'b0;
              nxt_pins.oe_n = 1'b0;
              nxt_pins.we_n = 1'b1;
              nxt_cnt = page_hit ? PACC_CYC : ACC_CYC;
              nxt_state = ST_RD;
            end
            OP_WRITE, OP_PROGRAM: begin
              nxt_steps = (req.op == OP_WRITE) ? 3'h1 : (shortened ? PROG_STEPS_SHORT : PROG_STEPS_FULL);
              nxt_pins = (req.op == OP_WRITE) ? drive_bus(pins_ff, req.addr, req.wdata, byte_mode, 1'b1)
                : drive_bus(pins_ff, first_word[UADDR_W+DATA_W-1:DATA_W], first_word[DATA_W-1:0], byte_mode, 1'b1);
              nxt_pins.accel_hv = (req.op == OP_PROGRAM) && accel_req;
              nxt_page_valid = 1'b0;
              nxt_pins.ce_n = 1'b0;
              nxt_pins.oe_n = 1'b1;
              nxt_pins.we_n = 1'b1;
              nxt_cnt = WE_HIGH_CYC;
              nxt_state = ST_WR_SET;
            end
            OP_BUF_LOAD: begin
              nxt_fill = fill_ff + 1'b1;
            end
            OP_BUF_FLUSH: begin
              nxt_page_valid = 1'b0;
              nxt_idx = '0;
              nxt_flush = 1'b1;
              nxt_steps = 3'h1;
              nxt_pins.accel_hv = accel_req;
              nxt_state = (fill_ff == '0) ? ST_WR_END : ST_BUF_RD;
            end
            OP_RESET: begin
              // Aborts whatever the device is doing; the caller reissues it afterwards
              nxt_page_valid = 1'b0;
              nxt_pins = drive_bus(pins_ff, req.addr, '0, byte_mode, 1'b0);
              nxt_pins.reset_n = 1'b0;
              nxt_pins.ce_n = 1'b1;
              nxt_pins.oe_n = 1'b1;
              nxt_pins.we_n = 1'b1;
              nxt_pins.accel_hv = 1'b0;
              nxt_cnt = RST_LOW_CYC;
              nxt_rst_rec = 1'b0;
              nxt_state = ST_RST;
            end
            default: begin
              nxt_state = ST_IDLE;
            end
          endcase
        end
      end
      ST_RD: begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff == CNT_ONE) begin
          nxt_rsp_data = byte_mode ? {8'h00, dq_in[BYTE_W-1:0]} : dq_in;
          nxt_rsp_valid = 1'b1;
          // Chip select stays low so the next read in this page is a fast one
          nxt_pins.oe_n = 1'b1;
          nxt_page_valid = 1'b1;
          nxt_page = base_ff[UADDR_W-1:PAGE_LSB];
          nxt_state = ST_IDLE;
        end
      end
      ST_WR_SET: begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff == CNT_ONE) begin
          nxt_pins.we_n = 1'b0;
          nxt_cnt = WE_LOW_CYC;
          nxt_state = ST_WR_LO;
        end
      end
      ST_WR_LO: begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff == CNT_ONE) begin
          nxt_pins.we_n = 1'b1;
          nxt_step = step_ff + 1'b1;
          nxt_state = ST_WR_END;
        end
      end
      ST_WR_END: begin
        // One cycle of data hold after the strobe rises
        if (flush_ff && idx_ff + 1'b1 < fill_ff) begin
          nxt_idx = idx_ff + 1'b1;
          nxt_state = ST_BUF_RD;
        end else if (!flush_ff && step_ff < steps_ff) begin
          nxt_pins = drive_bus(pins_ff, step_word[UADDR_W+DATA_W-1:DATA_W], step_word[DATA_W-1:0],
                               byte_mode, 1'b1);
          nxt_cnt = WE_HIGH_CYC;
          nxt_state = ST_WR_SET;
        end else begin
          // Chip select may rise now; the device finishes the operation by itself
          nxt_pins.ce_n = 1'b1;
          nxt_pins.dq_oe = byte_mode ? {1'b1, 15'h0000} : '0;
          nxt_pins.accel_hv = 1'b0;
          if (flush_ff) begin
            nxt_fill = '0;
          end
          nxt_rsp_valid = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      ST_BUF_RD: begin
        nxt_state = ST_BUF_LD;
      end
      ST_BUF_LD: begin
        nxt_pins = drive_bus(pins_ff, flush_addr, buf_rd_data, byte_mode, 1'b1);
        nxt_pins.ce_n = 1'b0;
        nxt_pins.oe_n = 1'b1;
        nxt_cnt = WE_HIGH_CYC;
        nxt_state = ST_WR_SET;
      end
      ST_RST: begin
        nxt_cnt = cnt_ff - 1'b1;
        if (cnt_ff == CNT_ONE) begin
          if (!rst_rec_ff) begin
            nxt_pins.reset_n = 1'b1;
            nxt_cnt = RST_REC_CYC;
            nxt_rst_rec = 1'b1;
          end else begin
            // Device is back in array read; plain reads work without a command
            nxt_rsp_valid = 1'b1;
            nxt_state = ST_IDLE;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      pins_ff <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1, accel_hv: 1'b0,
                   addr: '0, dq_out: '0, dq_oe: '0};
      cnt_ff <= '0;
      rst_rec_ff <= 1'b0;
      page_valid_ff <= 1'b0;
      page_ff <= '0;
      step_ff <= '0;
      steps_ff <= '0;
      flush_ff <= 1'b0;
      fill_ff <= '0;
      idx_ff <= '0;
      base_ff <= '0;
      wdata_ff <= '0;
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= '0;
      rsp_sector_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      pins_ff <= nxt_pins;
      cnt_ff <= nxt_cnt;
      rst_rec_ff <= nxt_rst_rec;
      page_valid_ff <= nxt_page_valid;
      page_ff <= nxt_page;
      step_ff <= nxt_step;
      steps_ff <= nxt_steps;
      flush_ff <= nxt_flush;
      fill_ff <= nxt_fill;
      idx_ff <= nxt_idx;
      base_ff <= nxt_base;
      wdata_ff <= nxt_wdata;
      rsp_valid_ff <= nxt_rsp_valid;
      rsp_data_ff <= nxt_rsp_data;
      rsp_sector_ff <= nxt_rsp_sector;
    end
  end

  pfb_wbuf u_wbuf (
    .core_clk(core_clk),
    .wr_en(buf_wr_en),
    .wr_addr(fill_ff[WBUF_AW-1:0]),
    .wr_data(req.wdata),
    .rd_addr(idx_ff[WBUF_AW-1:0]),
    .rd_data(buf_rd_data)
  );

  assign pins = pins_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_data_ff;
  assign rsp_sector = rsp_sector_ff;

endmodule // pfb_host

// [hw/pfb_pkg.sv]
// Constants, types and timing figures for the parallel flash bus host controller
// Summary of operation
// - Host keeps upper page bits fixed and varies only low bits for page reads.
// - Host drives write strobe and chip select low with output gate high for writes.
// - In shortened program mode a word program takes two write cycles, not four.
// - Host applies high voltage only during accelerated programming.
// - Identifier reads use the same read cycle timing as array reads.
// - First read after standby is allowed the full select access time.
// - Host should reissue an operation interrupted by hardware reset; pfb_host does not, and leaves this to its caller.
package pfb_pkg;

  localparam int CLK_PERIOD_NS = 25;
  // Bus timing figures in ns
  localparam int ADDR_ACCESS_TIME_NS = 100;
  localparam int PAGE_ACCESS_TIME_NS = 30;
  localparam int WE_LOW_NS = 40;
  localparam int WE_HIGH_NS = 30;
  localparam int RESET_PULSE_MIN_NS = 500;
  localparam int RESET_RECOVERY_NS = 50;

  localparam int CNT_W = 8;

  function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[CNT_W-1:0];
  endfunction

  localparam logic [CNT_W-1:0] ACC_CYC = ns_to_cyc(ADDR_ACCESS_TIME_NS);
  localparam logic [CNT_W-1:0] PACC_CYC = ns_to_cyc(PAGE_ACCESS_TIME_NS);
  localparam logic [CNT_W-1:0] WE_LOW_CYC = ns_to_cyc(WE_LOW_NS);
  localparam logic [CNT_W-1:0] WE_HIGH_CYC = ns_to_cyc(WE_HIGH_NS);
  localparam logic [CNT_W-1:0] RST_LOW_CYC = ns_to_cyc(RESET_PULSE_MIN_NS);
  localparam logic [CNT_W-1:0] RST_REC_CYC = ns_to_cyc(RESET_RECOVERY_NS);
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // Addresses are byte form: bit 0 is the byte-lane address, bits 22:1 the word address
  localparam int UADDR_W = 23;
  localparam int PIN_ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int PAGE_LSB = 3;
  localparam int SECTOR_LSB = 16;
  localparam int SECTOR_W = 7;
  localparam int TOP_DQ = 15;

  localparam int WBUF_DEPTH = 16;
  localparam int WBUF_AW = 4;
  localparam logic [WBUF_AW:0] WBUF_FULL = 5'h10;

  // Command sequence words; command addresses are given as word addresses
  localparam logic [PIN_ADDR_W-1:0] CMD_ADDR1 = 22'h000555;
  localparam logic [PIN_ADDR_W-1:0] CMD_ADDR2 = 22'h0002aa;
  localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 16'h00aa;
  localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00a0;

  localparam logic [2:0] PROG_STEPS_FULL = 3'h4;
  localparam logic [2:0] PROG_STEPS_SHORT = 3'h2;

  typedef enum logic [2:0] {
    OP_READ,
    OP_WRITE,
    OP_PROGRAM,
    OP_BUF_LOAD,
    OP_BUF_FLUSH,
    OP_RESET
  } pfb_op_t;

  typedef struct packed {
    pfb_op_t op;
    logic [UADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pfb_req_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic accel_hv;
    logic [PIN_ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic [DATA_W-1:0] dq_oe;
  } pfb_pins_t;

  function automatic logic [SECTOR_W-1:0] sector_index(input logic [UADDR_W-1:0] a);
    return a[SECTOR_LSB +: SECTOR_W];
  endfunction

  function automatic logic [UADDR_W-1:0] cmd_uaddr(input logic [PIN_ADDR_W-1:0] w);
    return {w, 1'b0};
  endfunction

endpackage : pfb_pkg

// [hw/pfb_wbuf.sv]
// Small word store that holds the data of one buffered program
module pfb_wbuf (
  // Clock
  input wire logic core_clk,
  // Write side
  input wire logic wr_en,
  input wire logic [pfb_pkg::WBUF_AW-1:0] wr_addr,
  input wire logic [pfb_pkg::DATA_W-1:0] wr_data,
  // Read side
  input wire logic [pfb_pkg::WBUF_AW-1:0] rd_addr,
  output logic [pfb_pkg::DATA_W-1:0] rd_data
);
  import pfb_pkg::*;

  logic [DATA_W-1:0] mem_ff [WBUF_DEPTH];
  logic [DATA_W-1:0] rd_data_ff;

  // No reset: contents are only read after they are written
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
    rd_data_ff <= mem_ff[rd_addr];
  end

  assign rd_data = rd_data_ff;

endmodule // pfb_wbuf

// [tb/pfb_flash_model.sv]
// Behavioural model of the parallel flash as seen from its pins
module pfb_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h5a // Arbitrary identifier value
) (
  // Pins from the host
  input wire pfb_pkg::pfb_pins_t pins,
  input wire logic [15:0] bus,
  input wire logic width_n,
  // Data driven back
  output logic [15:0] dev_dq,
  output logic [15:0] dev_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  import pfb_pkg::*;
  logic [15:0] mem [int];
  logic [15:0] word = 16'hffff;
  logic [15:0] val;
  logic [1:0] st = 2'h0;
  logic prog = 1'b0;
  logic byp = 1'b0;
  logic idm = 1'b0;
  logic ers = 1'b0;
  logic ok = 1'b0;
  logic sel = 1'b0;
  logic [19:0] pg = '1;
  int stamp = 0;
  int nwr = 0;
  wire alo = !width_n & bus[15];
  wire drive = !pins.ce_n && !pins.oe_n && pins.reset_n && pins.we_n;

  function automatic logic [15:0] rd(input int w);
    return mem.exists(w) ? mem[w] : 16'hffff;
  endfunction

  assign val = idm ? {8'h00, ID_CODE} : !width_n ? {8'h00, alo ? word[15:8] : word[7:0]} : word;
  // Data not yet valid is shown inverted so an early sample cannot pass
  assign dev_dq = ok ? val : ~val;
  assign dev_oe = drive ? (width_n ? 16'hffff : 16'h00ff) : 16'h0000;

  always @(pins.addr, pins.ce_n, pins.oe_n, pins.reset_n, alo) begin : access
    automatic int s;
    automatic int d;
    s = stamp + 1;
    stamp = s;
    d = (!pins.ce_n && sel && pins.addr[21:2] == pg) ? PAGE_ACCESS_TIME_NS : ADDR_ACCESS_TIME_NS;
    ok = 1'b0;
    sel = !pins.ce_n && pins.reset_n;
    pg = pins.addr[21:2];
    fork
      begin
        #(d - 1);
        if (s == stamp) begin
          word = rd(int'(pins.addr));
          ok = 1'b1;
        end
      end
    join_none
  end

  always @(posedge pins.we_n) begin : take_write
    automatic logic [7:0] c;
    automatic logic [11:0] a;
    c = bus[7:0];
    a = pins.addr[11:0];
    if (!pins.ce_n && pins.oe_n && pins.reset_n) begin
      nwr++;
      // Program and erase land at the strobe, so chip select rising later cannot cut them short
      if (prog) begin
        mem[int'(pins.addr)] = rd(int'(pins.addr)) & bus;
        prog = 1'b0;
      end else if (c == 8'ha0 && (st == 2'h2 || byp || pins.accel_hv)) begin
        prog = 1'b1;
      end else if (st == 2'h2 && c == 8'h20) begin
        byp = 1'b1;
      end else if (st == 2'h2 && c == 8'h80) begin
        ers = 1'b1;
      end else if (ers && st == 2'h2 && c == 8'h10) begin
        mem.delete();
        ers = 1'b0;
      end else if (ers && c == 8'h30) begin
        // Further sector words after the first add more sectors to the same erase
        for (int k = 0; k < 32'h8000; k++) begin
          if (mem.exists({pins.addr[21:15], k[14:0]})) begin
            mem.delete({pins.addr[21:15], k[14:0]});
          end
        end
      end else if (st == 2'h2 && c == 8'h90) begin
        idm = 1'b1;
      end else if (c == 8'hf0) begin
        idm = 1'b0;
      end
      st = (st == 2'h0 && c == 8'haa && a == 12'h555) ? 2'h1 : (st == 2'h1 && c == 8'h55 && a == 12'h2aa) ? 2'h2 : 2'h0;
    end
  end

  always @(negedge pins.reset_n) begin
    st = 2'h0;
    prog = 1'b0;
    byp = 1'b0;
    idm = 1'b0;
    ers = 1'b0;
  end
endmodule // pfb_flash_model

// [tb/pfb_host_properties.sv]
// Port-level assertions for the flash host sequencer
module pfb_host_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Request and answer
  input wire logic req_valid,
  input wire logic req_ready,
  input wire pfb_pkg::pfb_req_t req,
  input wire logic rsp_valid,
  input wire logic [pfb_pkg::DATA_W-1:0] rsp_data,
  input wire logic [pfb_pkg::SECTOR_W-1:0] rsp_sector,
  // Modes and pins
  input wire logic byte_mode,
  input wire logic bypass_mode,
  input wire logic accel_req,
  input wire pfb_pkg::pfb_pins_t pins,
  input wire logic [pfb_pkg::DATA_W-1:0] dq_in
);
  timeunit 1ns;
  timeprecision 100ps;
  import pfb_pkg::*;
  logic [7:0] low_cnt_ff;
  logic [7:0] nxt_low_cnt;
  wire take_hv = req_valid && req_ready && accel_req && (req.op == OP_PROGRAM || req.op == OP_BUF_FLUSH);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  always_comb begin
    nxt_low_cnt = pins.reset_n ? 8'h00 : (low_cnt_ff == 8'hff ? low_cnt_ff : low_cnt_ff + 8'h01);
  end
  always_ff @(posedge core_clk) begin
    low_cnt_ff <= rst ? 8'h00 : nxt_low_cnt;
  end

  write_strobe_a: assert property (!pins.we_n |-> !pins.ce_n && pins.oe_n)
    else $error("write strobe low without select or with gate low");
  we_width_a: assert property ($fell(pins.we_n) |-> !pins.we_n [*2] ##1 pins.we_n)
    else $error("write strobe low time wrong");
  no_fight_a: assert property (!pins.oe_n |-> pins.dq_oe[14:0] == 15'h0000)
    else $error("host drives data while output gate low");
  hv_scope_a: assert property (pins.accel_hv |-> pins.oe_n && pins.reset_n)
    else $error("high voltage outside programming");
  hv_cause_a: assert property ($rose(pins.accel_hv) |-> $past(take_hv) || $past(take_hv, 2))
    else $error("high voltage without accelerated program request");
  rst_width_a: assert property ($rose(pins.reset_n) |-> low_cnt_ff >= RST_LOW_CYC)
    else $error("device reset pulse too short");
  rst_quiet_a: assert property (!pins.reset_n |-> pins.ce_n && pins.we_n && pins.dq_oe[14:0] == 15'h0000)
    else $error("bus activity during device reset");
  rand_access_a: assert property ($fell(pins.ce_n) && !pins.oe_n |-> !pins.oe_n [*4])
    else $error("random read shorter than access time");
  page_access_a: assert property ($fell(pins.oe_n) |-> !pins.oe_n [*2])
    else $error("read shorter than page access time");
  sector_a: assert property (req_valid && req_ready |=> rsp_sector == $past(req.addr[22:16]))
    else $error("sector index does not follow request address");

  cover property (rsp_valid && !pins.ce_n);
  cover property (!pins.reset_n);
  cover property (pins.accel_hv && !pins.we_n);
  cover property (req_valid && !req_ready && req.op == OP_BUF_LOAD);
endmodule // pfb_host_properties

bind pfb_host pfb_host_properties chk (.core_clk, .rst, .req_valid, .req_ready, .req, .rsp_valid, .rsp_data,
  .rsp_sector, .byte_mode, .bypass_mode, .accel_req, .pins, .dq_in);

// [tb/pfb_host_test.sv]
// Self-checking bench for the flash host sequencer
module pfb_host_test;
  timeunit 1ns;
  timeprecision 100ps;
  import pfb_pkg::*;
  localparam logic [7:0] ID_VAL = 8'h3c; // Arbitrary identifier value
  // Strobe setup and low time plus one cycle of data hold per write
  localparam int WR_CYC = 1 + int'(WE_HIGH_CYC) + int'(WE_LOW_CYC);
  localparam int RND = int'(ACC_CYC);
  `define CHK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic byte_mode = 1'b0;
  logic bypass_mode = 1'b0;
  logic accel_req = 1'b0;
  pfb_req_t req = '0;
  logic req_ready;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic [6:0] rsp_sector;
  pfb_pins_t pins;
  logic [15:0] dq_in;
  logic [15:0] dev_dq;
  logic [15:0] dev_oe;
  logic [15:0] flt = 16'ha5a5;
  logic [15:0] q;
  int l;
  int n_errors = 0;
  int num_checks = 0;

  always #12.5 core_clk = ~core_clk;
  // Released lines toggle so that stale data never reads as good
  always @(posedge core_clk) flt <= ~flt;
  assign dq_in = (pins.dq_oe & pins.dq_out) | (~pins.dq_oe & dev_oe & dev_dq) | (~pins.dq_oe & ~dev_oe & flt);

  pfb_host uut (.core_clk, .rst, .req_valid, .req_ready, .req, .rsp_valid, .rsp_data, .rsp_sector,
    .byte_mode, .bypass_mode, .accel_req, .pins, .dq_in);
  pfb_flash_model #(.ID_CODE(ID_VAL)) flash (.pins, .bus(dq_in), .width_n(!byte_mode), .dev_dq, .dev_oe);

  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One request; l counts cycles from take to answer
  task automatic op(input pfb_op_t o, input logic [22:0] a, input logic [15:0] d);
    int i;
    i = 0;
    @(posedge core_clk);
    #1 req_valid = 1'b1;
    req = '{o, a, d};
    do begin
      @(posedge core_clk);
      i++;
    end while (req_ready !== 1'b1 && i < 100);
    #1 req_valid = 1'b0;
    l = 0;
    while (o != OP_BUF_LOAD && rsp_valid !== 1'b1 && l < 1000) begin
      @(posedge core_clk);
      #1 l++;
    end
    q = rsp_data;
    if (i >= 100 || l >= 1000) begin
      n_errors++;
      final_report();
    end
  endtask

  task automatic cmd3(input logic [7:0] c);
    op(OP_WRITE, {22'h000555, 1'b0}, 16'h00aa);
    op(OP_WRITE, {22'h0002aa, 1'b0}, 16'h0055);
    op(OP_WRITE, {22'h000555, 1'b0}, {8'h00, c});
  endtask

  task automatic t_read_prog();
    op(OP_READ, 23'h012340, 16'h0000);
    `CHK(q, 16'hffff)
    `CHK(l, RND)
    op(OP_PROGRAM, 23'h012340, 16'h1234);
    `CHK(l, 4 * WR_CYC)
    flash.mem[32'h000091a1] = 16'hbeef;
    op(OP_READ, 23'h012340, 16'h0000);
    `CHK(q, 16'h1234)
    `CHK(l, RND)
    op(OP_READ, 23'h012342, 16'h0000);
    `CHK(q, 16'hbeef)
    `CHK(l, int'(PACC_CYC))
    op(OP_READ, 23'h012348, 16'h0000);
    `CHK(l, RND)
  endtask

  task automatic t_bypass();
    cmd3(8'h20);
    bypass_mode = 1'b1;
    op(OP_PROGRAM, 23'h020006, 16'h00c3);
    `CHK(l, 2 * WR_CYC)
    `CHK(rsp_sector, 7'h02)
    bypass_mode = 1'b0;
    op(OP_READ, 23'h020006, 16'h0000);
    `CHK(q, 16'h00c3)
    op(OP_RESET, 23'h000000, 16'h0000);
    `CHK(l, int'(RST_LOW_CYC) + int'(RST_REC_CYC))
  endtask

  task automatic t_accel();
    accel_req = 1'b1;
    op(OP_PROGRAM, 23'h7f0010, 16'h0f0f);
    `CHK(l, 2 * WR_CYC)
    `CHK(rsp_sector, 7'h7f)
    accel_req = 1'b0;
    `CHK(pins.accel_hv, 1'b0)
    bypass_mode = 1'b1;
    op(OP_PROGRAM, 23'h7f0012, 16'h0000);
    bypass_mode = 1'b0;
    op(OP_READ, 23'h7f0010, 16'h0000);
    `CHK(q, 16'h0f0f)
    op(OP_READ, 23'h7f0012, 16'h0000);
    `CHK(q, 16'hffff)
  endtask

  task automatic t_ident();
    cmd3(8'h90);
    op(OP_READ, 23'h000000, 16'h0000);
    `CHK(q, {8'h00, ID_VAL})
    `CHK(l, RND)
    op(OP_RESET, 23'h000000, 16'h0000);
    op(OP_READ, 23'h012340, 16'h0000);
    `CHK(q, 16'h1234)
  endtask

  task automatic t_byte();
    byte_mode = 1'b1;
    op(OP_READ, 23'h012341, 16'h0000);
    `CHK(q, 16'h0012)
    op(OP_READ, 23'h012340, 16'h0000);
    `CHK(q, 16'h0034)
    `CHK(l, int'(PACC_CYC))
    byte_mode = 1'b0;
  endtask

  task automatic t_buffer();
    int n0;
    for (int k = 0; k < 16; k++) op(OP_BUF_LOAD, 23'h000000, {12'h000, k[3:0]});
    @(posedge core_clk);
    #1 req_valid = 1'b1;
    req = '{OP_BUF_LOAD, 23'h000000, 16'h0001};
    repeat (3) begin
      @(posedge core_clk);
      `CHK(req_ready, 1'b0)
    end
    #1 req_valid = 1'b0;
    n0 = flash.nwr;
    op(OP_BUF_FLUSH, 23'h030000, 16'h0000);
    `CHK(flash.nwr - n0, 16)
  endtask

  // Two sectors in one erase, a sector left alone, then the whole array
  task automatic t_erase();
    cmd3(8'h80);
    op(OP_WRITE, {22'h000555, 1'b0}, 16'h00aa);
    op(OP_WRITE, {22'h0002aa, 1'b0}, 16'h0055);
    op(OP_WRITE, 23'h010000, 16'h0030);
    op(OP_WRITE, 23'h020000, 16'h0030);
    op(OP_READ, 23'h012340, 16'h0000);
    `CHK(q, 16'hffff)
    op(OP_READ, 23'h020006, 16'h0000);
    `CHK(q, 16'hffff)
    op(OP_READ, 23'h7f0010, 16'h0000);
    `CHK(q, 16'h0f0f)
    cmd3(8'h80);
    cmd3(8'h10);
    op(OP_READ, 23'h7f0010, 16'h0000);
    `CHK(q, 16'hffff)
  endtask

  initial begin
    repeat (20) @(posedge core_clk);
    #1 rst = 1'b0;
    t_read_prog();
    t_bypass();
    t_accel();
    t_ident();
    t_byte();
    t_buffer();
    t_erase();
    final_report();
  end
endmodule // pfb_host_test
